/* core/fap_consts.svh */
/*
  Constants of the flash access protection block: geometry, level codes,
  state codes and reset values. Included by the package and by the design
  files that use the macros; the guard keeps a second inclusion harmless.
*/
`ifndef FAP_CONSTS_SVH
`define FAP_CONSTS_SVH

// ----------------------------------------------------------------------
// flash geometry
// ----------------------------------------------------------------------
`define FAP_BANKS        2
`define FAP_PAGES        256
`define FAP_PAGE_BYTES   2048
`define FAP_PAGE_W       8
`define FAP_OFS_W        11
`define FAP_ADDR_W       19
`define FAP_DW_W         16
`define FAP_DW_LSB       3
`define FAP_WRP_PER_BANK 2

// ----------------------------------------------------------------------
// readout protection level codes
// ----------------------------------------------------------------------
`define FAP_LVL0_CODE    2'h0
`define FAP_LVL1_CODE    2'h1
`define FAP_LVL2_CODE    2'h2

// ----------------------------------------------------------------------
// erase sequencer state codes (gray along idle, retained, exec-only)
// ----------------------------------------------------------------------
`define FAP_ST_IDLE      2'h0
`define FAP_ST_RET       2'h1
`define FAP_ST_XO        2'h3

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define FAP_RST_FLAG     1'h0
`define FAP_RST_LEVEL    2'h0

`endif

/* core/fap_pkg.sv */
/*
  Types of the flash access protection block: masters, operations, areas,
  levels, sequencer states and the request and region carriers.
  Assumes fap_consts.svh is on the include path.
*/
`include "fap_consts.svh"

package fap_pkg;

  typedef enum logic [1:0] {
    FAP_M_IFETCH = 2'h0,
    FAP_M_DREAD  = 2'h1,
    FAP_M_DMA    = 2'h2,
    FAP_M_DEBUG  = 2'h3
  } fap_master_type;

  typedef enum logic [1:0] {
    FAP_OP_READ  = 2'h0,
    FAP_OP_PROG  = 2'h1,
    FAP_OP_ERASE = 2'h2
  } fap_op_type;

  typedef enum logic [2:0] {
    FAP_A_MAIN   = 3'h0,
    FAP_A_SYSTEM = 3'h1,
    FAP_A_OPTION = 3'h2,
    FAP_A_BACKUP = 3'h3,
    FAP_A_SRAM   = 3'h4
  } fap_area_type;

  typedef enum logic [1:0] {
    FAP_LVL0 = `FAP_LVL0_CODE,
    FAP_LVL1 = `FAP_LVL1_CODE,
    FAP_LVL2 = `FAP_LVL2_CODE
  } fap_level_type;

  typedef enum logic [1:0] {
    FAP_ST_IDLE = `FAP_ST_IDLE,
    FAP_ST_RET  = `FAP_ST_RET,
    FAP_ST_XO   = `FAP_ST_XO
  } fap_state_type;

  typedef struct packed {
    fap_master_type          master;
    fap_op_type              op;
    fap_area_type            area;
    logic                    bank;
    logic [`FAP_ADDR_W-1:0]  addr;
  } fap_req_type;

  // empty when first page is above last page
  typedef struct packed {
    logic [`FAP_PAGE_W-1:0] first;
    logic [`FAP_PAGE_W-1:0] last;
  } fap_wrp_type;

  // bounds are 64-bit double-word indexes within the bank
  typedef struct packed {
    logic [`FAP_DW_W-1:0] first;
    logic [`FAP_DW_W-1:0] last;
  } fap_xo_type;

endpackage

/* core/fap_erase_seq.sv */
/*
  Erase sequencer: on a protection downgrade, clears the retained memories
  and optionally the execute-only areas. Each step is held until the memory
  side answers with a done pulse.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fap_consts.svh"

module fap_erase_seq
  import fap_pkg::*;
(
  // clock and control
  input  wire logic core_clk_i,
  input  wire logic rstn_i,
  input  wire logic ce_i,
  // command
  input  wire logic start_i,
  input  wire logic with_xo_i,
  input  wire logic done_i,
  // status and erase requests
  output logic      busy_o,
  output logic      erase_ret_o,
  output logic      erase_xo_o
);

  fap_state_type state;
  fap_state_type next_state;
  logic          with_xo;
  logic          next_with_xo;

  always_comb begin
    next_state   = state;
    next_with_xo = with_xo;
    case (state)
      FAP_ST_IDLE: begin
        if (start_i) begin
          next_state   = FAP_ST_RET;
          next_with_xo = with_xo_i;
        end
      end
      FAP_ST_RET: begin
        if (done_i) begin
          next_state = with_xo ? FAP_ST_XO : FAP_ST_IDLE;
        end
      end
      FAP_ST_XO: begin
        if (done_i) begin
          next_state = FAP_ST_IDLE;
        end
      end
      default: begin
        next_state = FAP_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state   <= FAP_ST_IDLE;
      with_xo <= `FAP_RST_FLAG;
    end else if (ce_i) begin
      state   <= next_state;
      with_xo <= next_with_xo;
    end
  end

  assign busy_o      = (state != FAP_ST_IDLE);
  assign erase_ret_o = (state == FAP_ST_RET);
  assign erase_xo_o  = (state == FAP_ST_XO);

endmodule

`default_nettype wire

/* core/fap_top.sv */
/*
  Flash access protection: checks each master request against the readout
  level, write-protected pages and execute-only windows of a dual-bank flash,
  and runs the retained-memory erase on a level 1 to level 0 downgrade.
  Assumes option settings are stable levels from the option loader and that
  the flash controller reports per-bank busy and erase completion.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fap_consts.svh"

// Operation
// (RULE1) two banks; a read of one bank proceeds while the other is busy
// (RULE2) each bank holds 256 pages of 2 Kbyte; page index stays in-bank
// (RULE3) three levels; level 0 puts no readout restriction on any access
// (RULE4) level 1 blocks main flash under debugger, RAM boot or bootloader
// (RULE5) level 2 disables debug, RAM boot, bootloader; level cannot change again
// (RULE6) system memory never written; option bytes read-only at level 2
// (RULE7) downgrade from level 1 to 0 erases backup and retention sram first
// (RULE8) two write-protected page ranges per bank reject program and erase
// (RULE9) execute-only window grants only CPU instruction fetches
// (RULE10) one execute-only window per bank, bounds in 64-bit words
// (RULE11) option bit chooses whether downgrade also erases execute-only windows
// (RULE12) prohibited access is dropped, answered with error, sets sticky flag
module fap_top
  import fap_pkg::*;
(
  // clock, reset, enable
  input  wire logic                core_clk_i,
  input  wire logic                resetn_i,
  input  wire logic                ce_i,
  // request and answer
  input  wire logic                req_valid_i,
  input  wire fap_req_type         req_i,
  output logic                     req_ready_o,
  output logic                     resp_valid_o,
  output logic                     resp_err_o,
  output logic                     flash_go_o,
  // option settings
  input  wire logic [1:0]          level_code_i,
  input  wire fap_wrp_type [3:0]   wrp_area_i,
  input  wire fap_xo_type  [1:0]   xo_area_i,
  input  wire logic                xo_erase_on_downgrade_i,
  // execution context
  input  wire logic                debug_attached_i,
  input  wire logic                boot_ram_i,
  input  wire logic                bootloader_i,
  // flash and memory side
  input  wire logic [1:0]          bank_busy_i,
  input  wire logic                erase_done_i,
  output logic                     erase_backup_o,
  output logic                     erase_sram_o,
  output logic                     erase_xo_o,
  // status
  output fap_level_type            level_o,
  output logic                     debug_enable_o,
  output logic                     boot_alt_enable_o,
  output logic                     viol_flag_o,
  input  wire logic                viol_clear_i
);

  // ----------------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta <= 1'h0;
      rst_n    <= 1'h0;
    end else begin
      rst_meta <= 1'h1;
      rst_n    <= rst_meta;
    end
  end

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic wrp_hit(input fap_wrp_type a, input logic [`FAP_PAGE_W-1:0] pg);
    wrp_hit = (pg >= a.first) && (pg <= a.last);
  endfunction

  function automatic logic xo_hit(input fap_xo_type a, input logic [`FAP_DW_W-1:0] dw);
    xo_hit = (dw >= a.first) && (dw <= a.last);
  endfunction

  function automatic fap_level_type level_of(input logic [1:0] code);
    // unknown code falls back to level 1, the safer choice
    if (code == `FAP_LVL0_CODE) begin
      level_of = FAP_LVL0;
    end else if (code == `FAP_LVL2_CODE) begin
      level_of = FAP_LVL2;
    end else begin
      level_of = FAP_LVL1;
    end
  endfunction

  // ----------------------------------------------------------------------
  // protection level tracking
  // ----------------------------------------------------------------------
  logic          locked;
  logic          next_locked;
  fap_level_type prev_level;
  fap_level_type level;
  logic          downgrade;
  logic          erase_busy;

  always_comb begin
    next_locked = locked | (level_code_i == `FAP_LVL2_CODE); // RULE5
    level       = locked ? FAP_LVL2 : level_of(level_code_i); // RULE5 RULE3
    downgrade   = (prev_level == FAP_LVL1) && (level == FAP_LVL0); // RULE7
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      locked     <= `FAP_RST_FLAG;
      prev_level <= fap_level_type'(`FAP_RST_LEVEL);
    end else if (ce_i) begin
      locked     <= next_locked;
      prev_level <= level;
    end
  end

  assign level_o           = prev_level;
  assign debug_enable_o    = !locked; // RULE5
  assign boot_alt_enable_o = !locked; // RULE5

  // ----------------------------------------------------------------------
  // downgrade erase
  // ----------------------------------------------------------------------
  logic erase_ret;

  fap_erase_seq u_erase (
    .core_clk_i (core_clk_i),
    .rstn_i     (rst_n),
    .ce_i       (ce_i),
    .start_i    (downgrade),                // RULE7
    .with_xo_i  (xo_erase_on_downgrade_i),  // RULE11
    .done_i     (erase_done_i),
    .busy_o     (erase_busy),
    .erase_ret_o(erase_ret),
    .erase_xo_o (erase_xo_o)
  );

  assign erase_backup_o = erase_ret;
  assign erase_sram_o   = erase_ret;

  // ----------------------------------------------------------------------
  // access check
  // ----------------------------------------------------------------------
  logic [`FAP_PAGE_W-1:0] page;
  logic [`FAP_DW_W-1:0]   dword;
  logic                   restricted;
  logic                   in_wrp;
  logic                   in_xo;
  logic                   deny;
  logic                   taken;

  always_comb begin
    page       = req_i.addr[`FAP_ADDR_W-1:`FAP_OFS_W]; // RULE2
    dword      = req_i.addr[`FAP_ADDR_W-1:`FAP_DW_LSB]; // RULE10
    restricted = !locked && (debug_attached_i || boot_ram_i || bootloader_i);
    in_wrp     = wrp_hit(wrp_area_i[{req_i.bank, 1'h0}], page) ||
                 wrp_hit(wrp_area_i[{req_i.bank, 1'h1}], page); // RULE8
    in_xo      = xo_hit(xo_area_i[req_i.bank], dword); // RULE10
    deny       = 1'h0;
    if (locked && (req_i.master == FAP_M_DEBUG)) begin
      deny = 1'h1; // RULE5
    end
    if ((req_i.area == FAP_A_SYSTEM) && (req_i.op != FAP_OP_READ)) begin
      deny = 1'h1; // RULE6
    end
    if ((req_i.area == FAP_A_OPTION) && locked && (req_i.op != FAP_OP_READ)) begin
      deny = 1'h1; // RULE6
    end
    if ((level == FAP_LVL1) && restricted &&
        ((req_i.area == FAP_A_MAIN) || (req_i.area == FAP_A_BACKUP) ||
         (req_i.area == FAP_A_SRAM))) begin
      deny = 1'h1; // RULE4
    end
    if ((req_i.area == FAP_A_MAIN) && (req_i.op != FAP_OP_READ) && in_wrp) begin
      deny = 1'h1; // RULE8
    end
    if ((req_i.area == FAP_A_MAIN) && in_xo &&
        !((req_i.master == FAP_M_IFETCH) && (req_i.op == FAP_OP_READ))) begin
      deny = 1'h1; // RULE9
    end
  end

  // only the addressed bank stalls; erase holds every access off, and so does
  // the downgrade cycle itself, so nothing slips in before the erase starts
  assign req_ready_o = !erase_busy && !downgrade &&
                       !((req_i.area == FAP_A_MAIN) && bank_busy_i[req_i.bank]); // RULE1 RULE7
  assign taken       = ce_i && req_valid_i && req_ready_o;

  // ----------------------------------------------------------------------
  // answer and violation flag
  // ----------------------------------------------------------------------
  logic next_resp_valid;
  logic next_resp_err;
  logic next_flash_go;
  logic next_viol;

  always_comb begin
    next_resp_valid = taken;
    next_resp_err   = taken && deny; // RULE12
    next_flash_go   = taken && !deny; // RULE12
    next_viol       = (viol_flag_o && !viol_clear_i) || (taken && deny); // RULE12
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      resp_valid_o <= `FAP_RST_FLAG;
      resp_err_o   <= `FAP_RST_FLAG;
      flash_go_o   <= `FAP_RST_FLAG;
      viol_flag_o  <= `FAP_RST_FLAG;
    end else if (ce_i) begin
      resp_valid_o <= next_resp_valid;
      resp_err_o   <= next_resp_err;
      flash_go_o   <= next_flash_go;
      viol_flag_o  <= next_viol;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n || !ce_i);

  property p_rww;
    req_valid_i && !erase_busy && !downgrade && (req_i.op == FAP_OP_READ) &&
      !bank_busy_i[req_i.bank] |-> req_ready_o;
  endproperty
  a_rww: assert property (p_rww) else $error("idle bank read stalled"); // RULE1

  property p_level0_open;
    taken && (level == FAP_LVL0) && (req_i.area == FAP_A_MAIN) &&
      (req_i.op == FAP_OP_READ) && !in_xo |=> resp_valid_o && !resp_err_o;
  endproperty
  a_level0_open: assert property (p_level0_open) else $error("level 0 read refused"); // RULE3

  property p_level1_block;
    taken && (level == FAP_LVL1) && restricted && (req_i.area == FAP_A_MAIN)
      |=> resp_err_o && !flash_go_o;
  endproperty
  a_level1_block: assert property (p_level1_block) else $error("restricted access passed"); // RULE4

  property p_level2_lock;
    $past(locked) |-> locked && (level_o == FAP_LVL2) && !debug_enable_o;
  endproperty
  a_level2_lock: assert property (p_level2_lock) else $error("level 2 not permanent"); // RULE5

  property p_sysmem;
    taken && (req_i.area == FAP_A_SYSTEM) && (req_i.op != FAP_OP_READ) |=> resp_err_o;
  endproperty
  a_sysmem: assert property (p_sysmem) else $error("system memory write passed"); // RULE6

  property p_downgrade_erase;
    downgrade && !erase_busy |-> !req_ready_o ##1
      (erase_backup_o && erase_sram_o && !req_ready_o);
  endproperty
  a_downgrade_erase: assert property (p_downgrade_erase) else $error("no erase"); // RULE7

  property p_wrp;
    taken && (req_i.area == FAP_A_MAIN) && (req_i.op != FAP_OP_READ) && in_wrp
      |=> resp_err_o;
  endproperty
  a_wrp: assert property (p_wrp) else $error("protected page modified"); // RULE8

  property p_xo;
    taken && (req_i.area == FAP_A_MAIN) && in_xo && (req_i.master != FAP_M_IFETCH)
      |=> resp_err_o;
  endproperty
  a_xo: assert property (p_xo) else $error("execute-only data access passed"); // RULE9

  property p_viol;
    resp_err_o |-> viol_flag_o ##1 (viol_flag_o || $past(viol_clear_i));
  endproperty
  a_viol: assert property (p_viol) else $error("violation flag lost"); // RULE12

  c_downgrade: cover property (downgrade ##[1:20] erase_xo_o);
  c_refused:   cover property (taken && deny ##1 resp_err_o);
  c_rww:       cover property (req_valid_i && bank_busy_i[0] && req_i.bank && req_ready_o);
  c_lock:      cover property (!locked ##1 locked);

endmodule

`default_nettype wire

/* testbench/fap_mem_model.sv */
/*
  Memory-side partner: answers each erase step with a one-cycle done pulse.
  Assumes erase requests are levels held until their done is seen.
*/
`timescale 1ns/1ps
`default_nettype none

module fap_mem_model #(
  parameter int DLY = 3
) (
  // clock
  input  wire logic core_clk_i,
  // erase handshake
  input  wire logic erase_i,
  output logic      done_o
);
  logic [7:0] cnt;

  // slow on purpose: each step stays open DLY+1 cycles before done
  always_ff @(posedge core_clk_i) begin
    if (!erase_i || done_o) begin
      cnt    <= 8'h00;
      done_o <= 1'b0;
    end else begin
      cnt    <= cnt + 8'h01;
      done_o <= (cnt == DLY[7:0]);
    end
  end
endmodule

`default_nettype wire

/* testbench/flash_access_protection_test.sv */
/*
  Self-checking bench of the access protection block: requests from all
  masters against levels, write-protected pages and execute-only windows.
  Assumes the erase partner model answers every erase step.
*/
`timescale 1ns/1ps
`default_nettype none

module flash_access_protection_test
  import fap_pkg::*;
;
  logic clk, resetn, ce, req_valid, xo_opt, dbg, bram, bl, viol_clr;
  logic [1:0] lvl, busy;
  fap_req_type req;
  fap_wrp_type [3:0] write_protect_area;
  fap_xo_type [1:0] xo;
  logic rdy, rv, rerr, go, e_bk, e_sr, e_xo, done, dbg_en, alt_en, viol;
  fap_level_type lvl_o;
  wire logic e_any = e_bk | e_sr | e_xo;
  int n_fail, cmp_count, cyc, n_ret, n_xo, n_bad, n;

  fap_top u_dut (
    .core_clk_i(clk), .resetn_i(resetn), .ce_i(ce), .req_valid_i(req_valid),
    .req_i(req), .req_ready_o(rdy), .resp_valid_o(rv), .resp_err_o(rerr),
    .flash_go_o(go), .level_code_i(lvl), .wrp_area_i(write_protect_area), .xo_area_i(xo),
    .xo_erase_on_downgrade_i(xo_opt), .debug_attached_i(dbg), .boot_ram_i(bram),
    .bootloader_i(bl), .bank_busy_i(busy), .erase_done_i(done),
    .erase_backup_o(e_bk), .erase_sram_o(e_sr), .erase_xo_o(e_xo), .level_o(lvl_o),
    .debug_enable_o(dbg_en), .boot_alt_enable_o(alt_en), .viol_flag_o(viol),
    .viol_clear_i(viol_clr));

  fap_mem_model u_mem (.core_clk_i(clk), .erase_i(e_any), .done_o(done));

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %b seen %b", name, exp, got);
    end
  endtask

  // hold the request until ready, answer is looked at one cycle after
  task automatic access(input fap_master_type m, input fap_op_type op,
                        input fap_area_type a, input logic bk,
                        input logic [18:0] ad, input logic err);
    @(posedge clk);
    req_valid <= 1'b1;
    req       <= '{m, op, a, bk, ad};
    n = 0;
    @(negedge clk);
    while (rdy !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    req_valid <= 1'b0;
    @(negedge clk);
    chk("resp_valid", 1'b1, rv);
    chk("resp_err", err, rerr);
    chk("flash_go", !err, go);
  endtask

  task automatic wait_lvl(input fap_level_type l);
    n = 0;
    while (lvl_o !== l && n < 10) begin
      @(negedge clk);
      n++;
    end
    chk("level", 1'b1, lvl_o === l);
  endtask

  // downgrade to level 0 and wait for the erase sequence to end
  task automatic downgrade(input logic opt);
    n_ret = 0;
    n_xo  = 0;
    n_bad = 0;
    @(posedge clk);
    xo_opt <= opt;
    lvl    <= 2'h0;
    n = 0;
    @(negedge clk);
    while (!e_any && n < 20) begin
      @(negedge clk);
      n++;
    end
    while (e_any && n < 200) begin
      @(negedge clk);
      n++;
    end
  endtask

  // ----------------------------------------------------------------------
  // monitor and timeout
  // ----------------------------------------------------------------------
  always @(negedge clk) begin
    if (e_any === 1'b1) begin
      n_ret = n_ret + (e_bk & e_sr);
      n_xo  = n_xo + e_xo;
      if (rdy !== 1'b0 || e_bk !== e_sr) n_bad++;
    end
  end

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      $display("[FAIL] timeout expected finish seen %0d cycles", cyc);
      final_report();
    end
  end

  // ----------------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    ce = 1'b1;
    req_valid = 1'b0;
    req = '0;
    lvl = 2'h0;
    xo_opt = 1'b0;
    {dbg, bram, bl, viol_clr} = 4'h0;
    busy = 2'h0;
    write_protect_area = {4{16'hff00}};
    xo = {2{32'hffff0000}};
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    dbg <= 1'b1;
    for (int i = 0; i < 4; i++) access(fap_master_type'(i), FAP_OP_READ, FAP_A_MAIN, 1'b0, 19'h00100, 1'b0);
    @(posedge clk) dbg <= 1'b0;
    for (int i = 0; i < 3; i++) access(FAP_M_DREAD, fap_op_type'(i), FAP_A_SYSTEM, 1'b0, 19'h0, i != 0);
    chk("viol_set", 1'b1, viol);
    @(posedge clk) viol_clr <= 1'b1;
    @(posedge clk) viol_clr <= 1'b0;
    @(negedge clk) chk("viol_clear", 1'b0, viol);
    // a request while the clock enable is low is neither taken nor answered
    @(posedge clk) begin
      ce        <= 1'b0;
      req_valid <= 1'b1;
      req       <= '{FAP_M_DREAD, FAP_OP_PROG, FAP_A_SYSTEM, 1'b0, 19'h0};
    end
    repeat (3) @(posedge clk);
    req_valid <= 1'b0;
    @(negedge clk) chk("ce_frozen", 1'b0, rv | viol);
    @(posedge clk) ce <= 1'b1;
    // write-protect: bank 0 pages 5..6, bank 1 page 0
    @(posedge clk) begin
      write_protect_area[0] <= '{8'h05, 8'h06};
      write_protect_area[2] <= '{8'h00, 8'h00};
    end
    access(FAP_M_DREAD, FAP_OP_PROG, FAP_A_MAIN, 1'b0, 19'h03000, 1'b1);
    access(FAP_M_DREAD, FAP_OP_ERASE, FAP_A_MAIN, 1'b0, 19'h02800, 1'b1);
    access(FAP_M_DREAD, FAP_OP_READ, FAP_A_MAIN, 1'b0, 19'h02800, 1'b0);
    access(FAP_M_DREAD, FAP_OP_PROG, FAP_A_MAIN, 1'b0, 19'h03800, 1'b0);
    access(FAP_M_DMA, FAP_OP_ERASE, FAP_A_MAIN, 1'b1, 19'h007ff, 1'b1);
    access(FAP_M_DMA, FAP_OP_ERASE, FAP_A_MAIN, 1'b0, 19'h00000, 1'b0);
    // execute-only window: bank 1 double-words 0x10..0x11
    @(posedge clk) xo[1] <= '{16'h0010, 16'h0011};
    for (int i = 0; i < 4; i++) access(fap_master_type'(i), FAP_OP_READ, FAP_A_MAIN, 1'b1, 19'h0008f, i != 0);
    access(FAP_M_IFETCH, FAP_OP_PROG, FAP_A_MAIN, 1'b1, 19'h00080, 1'b1);
    access(FAP_M_DREAD, FAP_OP_READ, FAP_A_MAIN, 1'b1, 19'h00090, 1'b0);
    access(FAP_M_DREAD, FAP_OP_READ, FAP_A_MAIN, 1'b1, 19'h0007f, 1'b0);
    access(FAP_M_DREAD, FAP_OP_READ, FAP_A_MAIN, 1'b0, 19'h00080, 1'b0);
    // read of bank 1 while bank 0 is busy
    @(posedge clk) busy <= 2'h1;
    access(FAP_M_DREAD, FAP_OP_READ, FAP_A_MAIN, 1'b1, 19'h00200, 1'b0);
    @(posedge clk) req <= '{FAP_M_DREAD, FAP_OP_READ, FAP_A_MAIN, 1'b0, 19'h0};
    @(negedge clk) chk("ready_busy_bank", 1'b0, rdy);
    @(posedge clk) busy <= 2'h0;
    // level 1 under each restricted context
    @(posedge clk) lvl <= 2'h1;
    wait_lvl(FAP_LVL1);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk) {dbg, bram, bl} <= 3'h1 << i;
      access(FAP_M_IFETCH, fap_op_type'(i), FAP_A_MAIN, 1'b0, 19'h00100, 1'b1);
      access(FAP_M_DMA, FAP_OP_READ, FAP_A_BACKUP, 1'b0, 19'h0, 1'b1);
      access(FAP_M_DREAD, FAP_OP_PROG, FAP_A_OPTION, 1'b0, 19'h0, 1'b0);
    end
    @(posedge clk) {dbg, bram, bl} <= 3'h0;
    access(FAP_M_DREAD, FAP_OP_PROG, FAP_A_MAIN, 1'b0, 19'h00100, 1'b0);
    downgrade(1'b1);
    chk("retained_erased", 1'b1, n_ret > 0);
    chk("xo_erased", 1'b1, n_xo > 0);
    chk("ready_low_erase", 1'b0, n_bad > 0);
    wait_lvl(FAP_LVL0);
    access(FAP_M_DMA, FAP_OP_READ, FAP_A_SRAM, 1'b0, 19'h0, 1'b0);
    @(posedge clk) lvl <= 2'h3;
    wait_lvl(FAP_LVL1);
    downgrade(1'b0);
    chk("retained_erased2", 1'b1, n_ret > 0);
    chk("xo_kept", 1'b0, n_xo > 0);
    // level 2 locks and cannot be left
    @(posedge clk) lvl <= 2'h2;
    wait_lvl(FAP_LVL2);
    chk("debug_enable", 1'b0, dbg_en);
    chk("boot_alt_enable", 1'b0, alt_en);
    @(posedge clk) lvl <= 2'h0;
    repeat (3) @(negedge clk);
    chk("level_stays", 1'b1, lvl_o === FAP_LVL2);
    access(FAP_M_DREAD, FAP_OP_PROG, FAP_A_OPTION, 1'b0, 19'h0, 1'b1);
    access(FAP_M_DREAD, FAP_OP_READ, FAP_A_OPTION, 1'b0, 19'h0, 1'b0);
    access(FAP_M_DEBUG, FAP_OP_READ, FAP_A_MAIN, 1'b0, 19'h00100, 1'b1);
    final_report();
  end
endmodule

`default_nettype wire
